// file: src/qar_cfg.sv
/*
 Register bank for queue admission thresholds and region access control, with the checks they steer.
 Assumes request inputs are synchronous to ref_clk and addresses are already translated.
*/
module qar_cfg
(
	// Clock and reset
	input  wire logic              ref_clk,
	input  wire logic              rst_n,
	// Register port
	input  wire qar_pkg::qar_bus_req_s bus,
	output      logic [31:0]       rdata,
	// Request check
	input  wire qar_pkg::qar_req_s req,
	output      qar_pkg::qar_resp_s resp
);
	import qar_pkg::*;

	logic [31:0]        regs_r   [NUM_REGS];
	logic [31:0]        regs_nxt [NUM_REGS];
	logic [31:0]        rdata_r;
	logic [31:0]        rdata_nxt;
	qar_resp_s          resp_r;
	qar_resp_s          resp_nxt;
	logic [63:0]        thr_all;
	logic [3:0]         level_thr;
	logic [GRAN_W-1:0]  req_gran;
	logic [GRAN_W-1:0]  dflt_max;
	logic [GRAN_W-1:0]  r0_min;
	logic [GRAN_W-1:0]  r0_max;
	logic               r0_hit;
	logic               in_range;
	logic [3:0]         enables;
	logic [3:0]         admit_min_priority_per_level [16];
	logic [15:0]        dflt_addr_mid;
	logic [11:0]        dflt_addr_top;
	logic               dflt_err_resp_sel;
	logic               dflt_secure_wr_allow;
	logic               dflt_secure_rd_allow;
	logic               dflt_nonsecure_wr_allow;
	logic               dflt_nonsecure_rd_allow;
	logic [15:0]        r0_lower_addr_mid;
	logic [11:0]        r0_lower_addr_top;
	logic [15:0]        r0_upper_addr_mid;
	logic [11:0]        r0_upper_addr_top;
	logic               r0_secure_wr_allow;
	logic               r0_secure_rd_allow;
	logic               r0_nonsecure_wr_allow;
	logic               r0_nonsecure_rd_allow;

	localparam logic [7:0]  REG_OFS  [NUM_REGS] = '{OFS_THR_LOW, OFS_THR_HIGH, OFS_DFLT_LOW, OFS_DFLT_HIGH,
		OFS_R0_LO_LOW, OFS_R0_LO_HIGH, OFS_R0_UP_LOW, OFS_R0_UP_HIGH};
	localparam logic [31:0] REG_MASK [NUM_REGS] = '{MASK_THR_LOW, MASK_THR_HIGH, MASK_DFLT_LOW, MASK_TOP,
		MASK_MID_EN, MASK_TOP, MASK_MID, MASK_TOP};
	localparam logic [31:0] REG_RST  [NUM_REGS] = '{RST_THR, RST_THR, RST_DFLT_LOW, RST_ZERO,
		RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO};

	// Picks the enable bit matching the request type
	function automatic logic type_allowed(input logic [3:0] en, input logic wr, input logic sec);
		logic [1:0] sel;
		sel = {sec, wr};
		case (sel)
			2'b11:   type_allowed = en[BIT_S_WR];
			2'b10:   type_allowed = en[BIT_S_RD];
			2'b01:   type_allowed = en[BIT_NS_WR];
			default: type_allowed = en[BIT_NS_RD];
		endcase
	endfunction : type_allowed

	// Offset decode shared by the write and read paths
	function automatic logic ofs_hit(input logic [7:0] a, input int idx);
		ofs_hit = (a == REG_OFS[idx]);
	endfunction : ofs_hit

	// Register file: no state gating on access, writes land the cycle they appear
	genvar gi;
	generate
		for (gi = 0; gi < NUM_REGS; gi++)
		begin : g_reg
			always_comb
			begin
				regs_nxt[gi] = regs_r[gi];
				if (bus.wr && ofs_hit(bus.addr, gi))
				begin
					regs_nxt[gi] = bus.wdata & REG_MASK[gi];
				end
			end

			always_ff @(posedge ref_clk or negedge rst_n)
			begin
				if (!rst_n)
				begin
					regs_r[gi] <= REG_RST[gi];
				end
				else
				begin
					regs_r[gi] <= regs_nxt[gi];
				end
			end
		end
	endgenerate

	// Read data one cycle after the strobe; unmapped offsets read zero
	always_comb
	begin
		rdata_nxt = 32'h0000_0000;
		if (bus.rd)
		begin
			for (int i = 0; i < NUM_REGS; i++)
			begin
				if (ofs_hit(bus.addr, i))
				begin
					rdata_nxt = regs_r[i];
				end
			end
		end
	end

	// Named fields of the stored words; reserved bits already hold zero
	always_comb
	begin
		thr_all                 = {regs_r[1], regs_r[0]};
		dflt_addr_mid           = regs_r[2][31:16];
		dflt_err_resp_sel       = regs_r[2][BIT_ERR_SEL];
		dflt_secure_wr_allow    = regs_r[2][BIT_S_WR];
		dflt_secure_rd_allow    = regs_r[2][BIT_S_RD];
		dflt_nonsecure_wr_allow = regs_r[2][BIT_NS_WR];
		dflt_nonsecure_rd_allow = regs_r[2][BIT_NS_RD];
		dflt_addr_top           = regs_r[3][11:0];
		r0_lower_addr_mid       = regs_r[4][31:16];
		r0_secure_wr_allow      = regs_r[4][BIT_S_WR];
		r0_secure_rd_allow      = regs_r[4][BIT_S_RD];
		r0_nonsecure_wr_allow   = regs_r[4][BIT_NS_WR];
		r0_nonsecure_rd_allow   = regs_r[4][BIT_NS_RD];
		r0_lower_addr_top       = regs_r[5][11:0];
		r0_upper_addr_mid       = regs_r[6][31:16];
		r0_upper_addr_top       = regs_r[7][11:0];
	end

	// One threshold per level; level 0 has no field and reads zero, so it admits everything
	genvar gl;
	generate
		for (gl = 0; gl < 16; gl++)
		begin : g_level
			always_comb
			begin
				admit_min_priority_per_level[gl] = thr_all[4*gl +: 4];
			end
		end
	endgenerate

	always_comb
	begin
		level_thr = admit_min_priority_per_level[req.fill_level];
	end

	// Address checks on 64 KB granules of the already translated address
	always_comb
	begin
		req_gran = req.addr[ADDR_W-1:GRAN_LSB];
		dflt_max = {dflt_addr_top, dflt_addr_mid};
		r0_min   = {r0_lower_addr_top, r0_lower_addr_mid};
		r0_max   = {r0_upper_addr_top, r0_upper_addr_mid};
		r0_hit   = (req_gran >= r0_min) && (req_gran <= r0_max);
		in_range = r0_hit || (req_gran <= dflt_max);
		// Region 0 wins over the default region wherever the two overlap
		if (r0_hit)
		begin
			enables = {r0_secure_wr_allow, r0_secure_rd_allow, r0_nonsecure_wr_allow, r0_nonsecure_rd_allow};
		end
		else
		begin
			enables = {dflt_secure_wr_allow, dflt_secure_rd_allow, dflt_nonsecure_wr_allow, dflt_nonsecure_rd_allow};
		end
	end

	always_comb
	begin
		resp_nxt             = '0;
		resp_nxt.valid       = req.valid;
		resp_nxt.admit       = req.valid && (req.prio >= level_thr);
		resp_nxt.access_ok   = req.valid && in_range && type_allowed(enables, req.is_write, req.is_secure);
		resp_nxt.region0_hit = req.valid && r0_hit;
		resp_nxt.err_sel     = dflt_err_resp_sel;
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rdata_r <= 32'h0000_0000;
			resp_r  <= '0;
		end
		else
		begin
			rdata_r <= rdata_nxt;
			resp_r  <= resp_nxt;
		end
	end

	assign rdata = rdata_r;
	assign resp  = resp_r;

	property p_admit;
		@(posedge ref_clk) disable iff (!rst_n)
		req.valid |=> resp.admit == ($past(req.prio) >= $past(level_thr));
	endproperty
	a_admit: assert property (p_admit) else $error("admission mismatch");

	property p_rd_latency;
		@(posedge ref_clk) disable iff (!rst_n)
		(bus.rd && bus.addr == OFS_DFLT_LOW && !bus.wr) |=> rdata == $past(regs_r[2]);
	endproperty
	a_rd_latency: assert property (p_rd_latency) else $error("read data not one cycle later");

	property p_thr_low_unused;
		@(posedge ref_clk) disable iff (!rst_n)
		regs_r[0][3:0] == 4'h0;
	endproperty
	a_thr_low_unused: assert property (p_thr_low_unused) else $error("low threshold nibble not zero");

	property p_write_lands;
		@(posedge ref_clk) disable iff (!rst_n)
		(bus.wr && bus.addr == OFS_THR_HIGH) |=> regs_r[1] == $past(bus.wdata);
	endproperty
	a_write_lands: assert property (p_write_lands) else $error("high threshold write lost");

	property p_top_unused;
		@(posedge ref_clk) disable iff (!rst_n)
		regs_r[3][31:12] == 20'h0 && regs_r[7][31:12] == 20'h0;
	endproperty
	a_top_unused: assert property (p_top_unused) else $error("unused upper bits set");

	property p_mid_unused;
		@(posedge ref_clk) disable iff (!rst_n)
		regs_r[6][15:0] == 16'h0;
	endproperty
	a_mid_unused: assert property (p_mid_unused) else $error("upper bound low bits set");

	property p_err_sel;
		@(posedge ref_clk) disable iff (!rst_n)
		req.valid |=> resp.err_sel == $past(regs_r[2][BIT_ERR_SEL]);
	endproperty
	a_err_sel: assert property (p_err_sel) else $error("error select not reflected");

	property p_r0_hit;
		@(posedge ref_clk) disable iff (!rst_n)
		(req.valid && req_gran == r0_min && r0_min <= r0_max) |=> resp.region0_hit;
	endproperty
	a_r0_hit: assert property (p_r0_hit) else $error("inclusive lower bound missed");

	property p_dflt_deny;
		@(posedge ref_clk) disable iff (!rst_n)
		(req.valid && !r0_hit && regs_r[2][3:0] == 4'h0) |=> !resp.access_ok;
	endproperty
	a_dflt_deny: assert property (p_dflt_deny) else $error("disabled default access allowed");

	property p_r0_gate;
		@(posedge ref_clk) disable iff (!rst_n)
		(req.valid && r0_hit && req.is_secure && req.is_write) |=> resp.access_ok == $past(regs_r[4][BIT_S_WR]);
	endproperty
	a_r0_gate: assert property (p_r0_gate) else $error("region 0 secure write gate wrong");

	property p_rdata_idle;
		@(posedge ref_clk) disable iff (!rst_n)
		!bus.rd |=> rdata == 32'h0000_0000;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data not cleared after read cycle");

	property p_level0_admit;
		@(posedge ref_clk) disable iff (!rst_n)
		(req.valid && req.fill_level == 4'h0) |=> resp.admit;
	endproperty
	a_level0_admit: assert property (p_level0_admit) else $error("request refused at empty level");

	property p_invalid_quiet;
		@(posedge ref_clk) disable iff (!rst_n)
		!req.valid |=> !resp.valid && !resp.admit && !resp.access_ok && !resp.region0_hit;
	endproperty
	a_invalid_quiet: assert property (p_invalid_quiet) else $error("answer flags set without a request");

	property p_dflt_range;
		@(posedge ref_clk) disable iff (!rst_n)
		(req.valid && !r0_hit && req_gran > dflt_max) |=> !resp.access_ok;
	endproperty
	a_dflt_range: assert property (p_dflt_range) else $error("access above default limit allowed");

	property p_r0_upper_incl;
		@(posedge ref_clk) disable iff (!rst_n)
		(req.valid && req_gran == r0_max && r0_min <= r0_max) |=> resp.region0_hit;
	endproperty
	a_r0_upper_incl: assert property (p_r0_upper_incl) else $error("inclusive upper bound missed");

	property p_r0_outside;
		@(posedge ref_clk) disable iff (!rst_n)
		(req.valid && (req_gran < r0_min || req_gran > r0_max)) |=> !resp.region0_hit;
	endproperty
	a_r0_outside: assert property (p_r0_outside) else $error("region 0 hit outside its bounds");

	property p_dflt_ns_rd;
		@(posedge ref_clk) disable iff (!rst_n)
		(req.valid && !r0_hit && req_gran <= dflt_max && !req.is_secure && !req.is_write)
			|=> resp.access_ok == $past(regs_r[2][BIT_NS_RD]);
	endproperty
	a_dflt_ns_rd: assert property (p_dflt_ns_rd) else $error("default nonsecure read gate wrong");

	property p_r0_ns_rd;
		@(posedge ref_clk) disable iff (!rst_n)
		(req.valid && r0_hit && !req.is_secure && !req.is_write) |=> resp.access_ok == $past(regs_r[4][BIT_NS_RD]);
	endproperty
	a_r0_ns_rd: assert property (p_r0_ns_rd) else $error("region 0 nonsecure read gate wrong");

	property p_reserved_low;
		@(posedge ref_clk) disable iff (!rst_n)
		regs_r[2][15:5] == 11'h000 && regs_r[4][15:4] == 12'h000 && regs_r[5][31:12] == 20'h0_0000;
	endproperty
	a_reserved_low: assert property (p_reserved_low) else $error("reserved bits of bound words set");

	property p_up_low_write;
		@(posedge ref_clk) disable iff (!rst_n)
		(bus.wr && bus.addr == OFS_R0_UP_LOW) |=> regs_r[6] == ($past(bus.wdata) & MASK_MID);
	endproperty
	a_up_low_write: assert property (p_up_low_write) else $error("upper bound low write lost");
endmodule : qar_cfg

// file: src/qar_pkg.sv
/*
 Constants, field layouts and carrier types for the queue admission and region access configuration block.
 Assumes a single 10 MHz clock, an asynchronous active-low reset and a plain register port.
*/
// Operation
// - Accept a request only when its priority is at or above the level's threshold.
// - Low threshold register holds levels 1..7 in nibbles [7:4]..[31:28]; [3:0] unused.
// - High threshold register holds levels 8..15 in nibbles [3:0]..[31:28].
// - Default limit low bits [31:16] give maximum address bits 31..16.
// - Default limit high bits [11:0] give maximum address bits 43..32; rest unused.
// - Limit is compared against the translated request address.
// - Default region bits 3..0 enable secure wr, secure rd, nonsecure wr, nonsecure rd.
// - Default limit low bit 4 selects the response for failed checks.
// - Region 0 minimum from lower-bound low [31:16] and lower-bound high [11:0].
// - Region 0 lower-bound low bits 3..0 gate the four request types.
// - Region 0 upper-bound low [31:16] give upper bound bits 31..16; [15:0] unused.
// - Region 0 upper-bound high [11:0] give upper bound bits 43..32; rest unused.
// - All registers readable and writable in every controller state.
// - Default limit low resets to 0x10: error select set, enables cleared.
package qar_pkg;
	localparam int          ADDR_W          = 44;
	localparam int          GRAN_LSB        = 16;
	localparam int          GRAN_W          = ADDR_W - GRAN_LSB;
	localparam logic [7:0]  OFS_THR_LOW     = 8'h60;
	localparam logic [7:0]  OFS_THR_HIGH    = 8'h64;
	localparam logic [7:0]  OFS_DFLT_LOW    = 8'h78;
	localparam logic [7:0]  OFS_DFLT_HIGH   = 8'h7c;
	localparam logic [7:0]  OFS_R0_LO_LOW   = 8'h80;
	localparam logic [7:0]  OFS_R0_LO_HIGH  = 8'h84;
	localparam logic [7:0]  OFS_R0_UP_LOW   = 8'h88;
	localparam logic [7:0]  OFS_R0_UP_HIGH  = 8'h8c;
	localparam logic [31:0] RST_THR         = 32'h0000_0000;
	localparam logic [31:0] RST_DFLT_LOW    = 32'h0000_0010;
	localparam logic [31:0] RST_ZERO        = 32'h0000_0000;
	localparam logic [31:0] MASK_THR_LOW    = 32'hffff_fff0;
	localparam logic [31:0] MASK_THR_HIGH   = 32'hffff_ffff;
	localparam logic [31:0] MASK_DFLT_LOW   = 32'hffff_001f;
	localparam logic [31:0] MASK_MID_EN     = 32'hffff_000f;
	localparam logic [31:0] MASK_MID        = 32'hffff_0000;
	localparam logic [31:0] MASK_TOP        = 32'h0000_0fff;
	localparam int          BIT_ERR_SEL     = 4;
	localparam int          BIT_S_WR        = 3;
	localparam int          BIT_S_RD        = 2;
	localparam int          BIT_NS_WR       = 1;
	localparam int          BIT_NS_RD       = 0;
	localparam int          NUM_REGS        = 8;

	typedef struct packed
	{
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} qar_bus_req_s;

	typedef struct packed
	{
		logic              valid;
		logic [ADDR_W-1:0] addr;
		logic              is_write;
		logic              is_secure;
		logic [3:0]        prio;
		logic [3:0]        fill_level;
	} qar_req_s;

	typedef struct packed
	{
		logic valid;
		logic admit;
		logic access_ok;
		logic region0_hit;
		logic err_sel;
	} qar_resp_s;
endpackage : qar_pkg

// file: testbench/qar_req_model.sv
/*
 Interconnect requester: presents one check request per call and returns the registered answer.
 Assumes a single calling process and addresses already translated.
*/
module qar_req_model
(
	// Clock
	input  wire logic               ref_clk,
	// Request side
	output      qar_pkg::qar_req_s  req,
	input  wire qar_pkg::qar_resp_s resp
);
	timeunit 1ns;
	timeprecision 100ps;
	import qar_pkg::*;
	initial req = '0;
	task automatic issue(input logic [43:0] a, input logic w, input logic s, input logic [3:0] p,
		input logic [3:0] f, output qar_resp_s r);
		@(posedge ref_clk);
		req <= '{valid: 1'b1, addr: a, is_write: w, is_secure: s, prio: p, fill_level: f};
		@(posedge ref_clk);
		// Released fields inverted so a stale request never looks current
		req <= '{valid: 1'b0, addr: ~a, is_write: ~w, is_secure: ~s, prio: ~p, fill_level: ~f};
		#1 r = resp;
	endtask : issue
endmodule : qar_req_model

// file: testbench/queue_admit_region_access_cfg_tb.sv
/*
 Self-checking bench: register map, admission thresholds and region access checks.
 Assumes the requester model and a 10 MHz clock.
*/
module queue_admit_region_access_cfg_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import qar_pkg::*;
	logic         ref_clk = 1'b0;
	logic         rst_n   = 1'b0;
	qar_bus_req_s bus     = '0;
	logic [31:0]  rdata;
	qar_req_s     req;
	qar_resp_s    resp;
	qar_resp_s    r;
	int           n_mismatch = 0;
	int           num_checks = 0;
	logic [7:0]   ofs [8] = '{OFS_THR_LOW, OFS_THR_HIGH, OFS_DFLT_LOW, OFS_DFLT_HIGH,
		OFS_R0_LO_LOW, OFS_R0_LO_HIGH, OFS_R0_UP_LOW, OFS_R0_UP_HIGH};
	logic [31:0]  msk [8] = '{MASK_THR_LOW, MASK_THR_HIGH, MASK_DFLT_LOW, MASK_TOP,
		MASK_MID_EN, MASK_TOP, MASK_MID, MASK_TOP};
	logic [43:0]  adr [5] = '{44'h001_0002_ffff, 44'h001_0003_0000, 44'h001_0004_0000,
		44'h001_0005_ffff, 44'h001_0006_0000};
	logic [3:0]   ens [5] = '{4'h5, 4'h0, 4'ha, 4'ha, 4'h0};
	always #50 ref_clk = ~ref_clk;
	qar_cfg qar_cfg_i (.ref_clk(ref_clk), .rst_n(rst_n), .bus(bus), .rdata(rdata), .req(req), .resp(resp));
	qar_req_model qar_req_model_i (.ref_clk(ref_clk), .req(req), .resp(resp));
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge ref_clk);
		bus <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge ref_clk);
		bus.rd <= 1'b0;
		#1 d = rdata;
	endtask : rd
	task automatic test_done;
		if (n_mismatch == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : test_done
	initial
	begin
		#200_000;
		n_mismatch++;
		test_done();
	end
	initial
	begin
		logic [31:0] d;
		repeat (8) @(posedge ref_clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 8; i++)
		begin
			rd(ofs[i], d);
			chk("reset value", d, (i == 2) ? RST_DFLT_LOW : RST_ZERO);
			wr(ofs[i], 32'hffff_ffff);
			rd(ofs[i], d);
			chk("writable bits", d, msk[i]);
		end
		// Unmapped offset must neither store nor answer
		wr(8'h70, 32'hffff_ffff);
		rd(8'h70, d);
		chk("unmapped read", d, 32'h0);
		// Threshold of level k is k: prio k admitted, k-1 refused
		wr(OFS_THR_LOW, 32'h7654_3210);
		wr(OFS_THR_HIGH, 32'hfedc_ba98);
		for (int lv = 0; lv < 16; lv++)
		begin
			qar_req_model_i.issue(44'h0, 1'b0, 1'b0, lv[3:0], lv[3:0], r);
			chk("admit at threshold", r.admit, 1'b1);
			chk("error select set", r.err_sel, 1'b1);
			if (lv > 0)
			begin
				qar_req_model_i.issue(44'h0, 1'b0, 1'b0, 4'(lv - 1), lv[3:0], r);
				chk("refuse below threshold", r.admit, 1'b0);
			end
		end
		// Default limit 0x001_0002 granule, region 0 spans 0x001_0004..0x001_0005
		wr(OFS_DFLT_LOW, 32'h0002_0005);
		wr(OFS_DFLT_HIGH, 32'h0000_0001);
		wr(OFS_R0_LO_LOW, 32'h0004_000a);
		wr(OFS_R0_LO_HIGH, 32'h0000_0001);
		wr(OFS_R0_UP_LOW, 32'h0005_0000);
		wr(OFS_R0_UP_HIGH, 32'h0000_0001);
		for (int k = 0; k < 20; k++)
		begin
			qar_req_model_i.issue(adr[k / 4], k[0], k[1], 4'h0, 4'h0, r);
			chk("access allowed", r.access_ok, ens[k / 4][k % 4]);
			chk("region 0 hit", r.region0_hit, (k / 4 == 2 || k / 4 == 3));
			chk("error select clear", r.err_sel, 1'b0);
			chk("response valid", r.valid, 1'b1);
		end
		// Reset in mid-run brings back the default word with every enable cleared
		@(posedge ref_clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		rd(OFS_DFLT_LOW, d);
		chk("reset again", d, RST_DFLT_LOW);
		@(posedge ref_clk);
		#1 chk("read data released", rdata, 32'h0);
		// Whole space in range, so only the cleared enables can refuse
		wr(OFS_DFLT_HIGH, MASK_TOP);
		wr(OFS_DFLT_LOW, 32'hffff_0010);
		for (int k = 0; k < 4; k++)
		begin
			qar_req_model_i.issue(adr[1], k[0], k[1], 4'h0, 4'h0, r);
			chk("default region disabled", r.access_ok, 1'b0);
			chk("error select after reset", r.err_sel, 1'b1);
		end
		test_done();
	end
endmodule : queue_admit_region_access_cfg_tb
